/* core/config_word_protection.sv */
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_prot_params.svh"
module config_word_protection
   import cfg_prot_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_psel,
   input  wire logic         i_penable,
   input  wire logic         i_pwrite,
   input  wire logic [15:0]  i_paddr,
   input  wire logic [31:0]  i_pwdata,
   output logic [31:0]       o_prdata,
   output logic              o_pready,
   output logic              o_pslverr,
   input  wire word_t        i_nv_config_word,
   output cfg_decode_s       o_cfg,
   input  wire self_req_s    i_self,
   output self_rsp_s         o_self,
   input  wire logic [`WORD_W-1:0] i_cpu_mem_rdata,
   input  wire cpu_req_s     i_cpu,
   output cpu_rsp_s          o_cpu,
   input  wire logic         i_pv_mode,
   input  wire ext_req_s     i_ext,
   input  wire word_t        i_ext_mem_rdata,
   output ext_rsp_s          o_ext
);
   state_s st;
   state_s next_st;
   logic   self_allow;
   logic   ext_in_prog;
   logic   ext_in_id;
   logic   cpu_in_prog;
   logic   cp_active;
   logic   apb_setup;
   logic   apb_write;

   if (ADDR_W < 12 || ADDR_W > 13)
   begin : g_bad_addr_w
      $error("config_word_protection: ADDR_W must be 12 or 13");
   end

   cfg_write_gate #(.AW(ADDR_W)) u_gate
   (
      .i_range (st.cfg[`CFG_WRP_HI:`CFG_WRP_LO]),
      .i_addr  (i_self.addr),
      .o_allow (self_allow)
   );

   assign ext_in_prog = ((i_ext.addr >> ADDR_W) == '0);
   assign ext_in_id   = (i_ext.addr >= `ID_BASE) && (i_ext.addr <= `ID_LAST);
   assign cpu_in_prog = ((i_cpu.addr >> ADDR_W) == '0);
   assign cp_active   = !st.cfg[`CFG_READOUT_N_BIT];
   assign apb_setup   = i_psel && !i_penable;
   assign apb_write   = i_psel && i_penable && i_pwrite;

   // Field decode
   assign o_cfg.valid                    = st.loaded;
   assign o_cfg.debug_mode_en            = !st.cfg[`CFG_DEBUG_SEL_N_BIT];
   assign o_cfg.self_write_protect_range = st.cfg[`CFG_WRP_HI:`CFG_WRP_LO];
   assign o_cfg.brownout_reset_enable    = st.cfg[`CFG_BROWNOUT_BIT];
   assign o_cfg.code_protect_active      = cp_active;
   assign o_cfg.reset_pin_external       = st.cfg[`CFG_RESET_PIN_BIT];
   assign o_cfg.reset_pin_pullup_en      = st.cfg[`CFG_RESET_PIN_BIT];
   assign o_cfg.powerup_timer_en         = !st.cfg[`CFG_PUT_DIS_BIT];
   assign o_cfg.watchdog_enable          = st.cfg[`CFG_WATCHDOG_BIT];

   assign o_prdata  = st.prdata;
   assign o_pslverr = st.pslverr;
   assign o_pready  = 1'b1;
   assign o_self    = st.self;
   assign o_cpu     = st.cpu;
   assign o_ext     = st.ext;

   always_comb
   begin
      next_st             = st;
      next_st.ext.ack     = 1'b0;
      next_st.ext.refused = 1'b0;
      next_st.ext.mem_we  = 1'b0;
      next_st.self.strobe = 1'b0;
      next_st.self.blocked = 1'b0;
      next_st.cpu.valid   = 1'b0;

      // Capture once after reset release
      if (!st.loaded)
      begin
         next_st.cfg    = i_nv_config_word | `CFGW_UNIMPL_MASK;
         next_st.loaded = 1'b1;
      end

      // Register read data prepared in the setup phase
      if (apb_setup)
      begin
         next_st.prdata  = '0;
         next_st.pslverr = 1'b0;
         case (i_paddr[15:2])
            `CTRL_INDEX:
            begin
               next_st.prdata[`CTRL_WREN_BIT] = st.wr_en;
            end
            `STATUS_INDEX:
            begin
               next_st.prdata[`ST_SELF_BLK_BIT] = st.self_blk_flag;
               next_st.prdata[`ST_EXT_REF_BIT]  = st.ext_ref_flag;
               next_st.prdata[`ST_LOADED_BIT]   = st.loaded;
            end
            `CFGW_INDEX:
            begin
               next_st.prdata[`WORD_W-1:0] = st.cfg;
            end
            default:
            begin
               next_st.pslverr = 1'b1;
            end
         endcase
      end

      // Writes take effect in the access phase; the word itself ignores them
      if (apb_write)
      begin
         case (i_paddr[15:2])
            `CTRL_INDEX:
            begin
               next_st.wr_en = i_pwdata[`CTRL_WREN_BIT];
            end
            `STATUS_INDEX:
            begin
               if (i_pwdata[`ST_SELF_BLK_BIT])
               begin
                  next_st.self_blk_flag = 1'b0;
               end
               if (i_pwdata[`ST_EXT_REF_BIT])
               begin
                  next_st.ext_ref_flag = 1'b0;
               end
            end
            default:
            begin
               next_st.wr_en = st.wr_en;
            end
         endcase
      end

      // Self-write gate, set after clear so an event is never lost
      if (i_self.req)
      begin
         next_st.self.addr = i_self.addr;
         next_st.self.data = i_self.data;
         if (st.loaded && st.wr_en && self_allow)
         begin
            next_st.self.strobe = 1'b1;
         end
         else
         begin
            next_st.self.blocked  = 1'b1;
            next_st.self_blk_flag = 1'b1;
         end
      end

      // CPU reads pass untouched; ID and config space stay hidden
      if (i_cpu.req)
      begin
         next_st.cpu.valid = 1'b1;
         next_st.cpu.rdata = cpu_in_prog ? i_cpu_mem_rdata : '0;
      end

      // Programmer access
      if (i_ext.req)
      begin
         next_st.ext.ack       = 1'b1;
         next_st.ext.rdata     = '0;
         next_st.ext.mem_addr  = i_ext.addr;
         next_st.ext.mem_wdata = i_ext.wdata;
         if (!i_pv_mode || !st.loaded)
         begin
            next_st.ext.refused = 1'b1;
         end
         else if (ext_in_id)
         begin
            if (i_ext.we)
            begin
               next_st.id[i_ext.addr[1:0]] = i_ext.wdata;
            end
            else
            begin
               next_st.ext.rdata = st.id[i_ext.addr[1:0]];
            end
         end
         else if (i_ext.addr == `CFGW_INDEX)
         begin
            if (i_ext.we)
            begin
               next_st.ext.mem_we = 1'b1;
            end
            else
            begin
               next_st.ext.rdata = st.cfg;
            end
         end
         else if (ext_in_prog)
         begin
            if (cp_active)
            begin
               next_st.ext.refused = i_ext.we;
            end
            else if (i_ext.we)
            begin
               next_st.ext.mem_we = 1'b1;
            end
            else
            begin
               next_st.ext.rdata = i_ext_mem_rdata;
            end
         end
         else
         begin
            next_st.ext.refused = 1'b1;
         end
         if (next_st.ext.refused)
         begin
            next_st.ext_ref_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st     <= '0;
         st.cfg <= `CFGW_ERASED;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_id_wr;
      i_ext.req && i_ext.we && i_pv_mode && st.loaded && ext_in_id;
   endsequence

   sequence s_id_gap;
      !i_ext.req;
   endsequence

   sequence s_id_rd;
      i_ext.req && !i_ext.we && i_pv_mode && (i_ext.addr == $past(i_ext.addr, 2));
   endsequence

   property p_cfg_load;
      !st.loaded |=> st.loaded && (st.cfg == ($past(i_nv_config_word) | `CFGW_UNIMPL_MASK));
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("config word not captured");

   property p_cfg_stable;
      st.loaded |=> $stable(st.cfg) && st.loaded;
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config word changed");

   property p_unimpl_ones;
      (o_prdata[`WORD_W-1:0] & `CFGW_UNIMPL_MASK) == `CFGW_UNIMPL_MASK
         || $past(i_paddr[15:2]) != `CFGW_INDEX || !$past(apb_setup);
   endproperty
   a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bit read 0");

   property p_brownout;
      $rose(st.loaded)
         |-> o_cfg.brownout_reset_enable == $past(i_nv_config_word[`CFG_BROWNOUT_BIT]);
   endproperty
   a_brownout: assert property (p_brownout) else $error("brown-out enable wrong");

   property p_put;
      $rose(st.loaded)
         |-> o_cfg.powerup_timer_en == !$past(i_nv_config_word[`CFG_PUT_DIS_BIT]);
   endproperty
   a_put: assert property (p_put) else $error("power-up timer enable wrong");

   property p_reset_pin;
      $rose(st.loaded)
         |-> o_cfg.reset_pin_external == $past(i_nv_config_word[`CFG_RESET_PIN_BIT])
         && o_cfg.reset_pin_pullup_en == o_cfg.reset_pin_external;
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin select wrong");

   property p_cp_read_zero;
      i_ext.req && !i_ext.we && i_pv_mode && st.loaded && cp_active && ext_in_prog
         |=> o_ext.ack && o_ext.rdata == '0;
   endproperty
   a_cp_read_zero: assert property (p_cp_read_zero) else $error("protected read leaked");

   property p_cp_no_write;
      i_ext.req && i_ext.we && cp_active && ext_in_prog |=> !o_ext.mem_we && o_ext.refused;
   endproperty
   a_cp_no_write: assert property (p_cp_no_write) else $error("protected write passed");

   property p_cpu_read;
      i_cpu.req && cpu_in_prog |=> o_cpu.valid && o_cpu.rdata == $past(i_cpu_mem_rdata);
   endproperty
   a_cpu_read: assert property (p_cpu_read) else $error("CPU read altered");

   property p_self_range;
      i_self.req && st.cfg[`CFG_WRP_HI:`CFG_WRP_LO] == `PROT_400 && i_self.addr < `BOUND_400
         |=> o_self.blocked && !o_self.strobe;
   endproperty
   a_self_range: assert property (p_self_range) else $error("protected self-write passed");

   property p_self_indep;
      i_self.req && st.loaded && st.wr_en && st.cfg[`CFG_WRP_HI:`CFG_WRP_LO] == `PROT_NONE
         && ((i_self.addr >> ADDR_W) == '0) |=> o_self.strobe && !o_self.blocked;
   endproperty
   a_self_indep: assert property (p_self_indep) else $error("self-write wrongly blocked");

   property p_id_closed;
      i_ext.req && !i_pv_mode |=> o_ext.refused && !o_ext.mem_we && o_ext.rdata == '0;
   endproperty
   a_id_closed: assert property (p_id_closed) else $error("access outside program mode");

   property p_id_readback;
      s_id_wr ##1 s_id_gap ##1 s_id_rd |=> o_ext.rdata == $past(i_ext.wdata, 3);
   endproperty
   a_id_readback: assert property (p_id_readback) else $error("ID word readback wrong");
endmodule
`default_nettype wire

/* shared/cfg_prot_params.svh */
`ifndef CFG_PROT_PARAMS_SVH
`define CFG_PROT_PARAMS_SVH
// Word and register map
`define WORD_W              14
`define CTRL_INDEX          14'h0000
`define STATUS_INDEX        14'h0001
`define CFGW_INDEX          14'h2007
// Configuration word fields
`define CFG_DEBUG_SEL_N_BIT 13
`define CFG_WRP_HI          11
`define CFG_WRP_LO          10
`define CFG_BROWNOUT_BIT    8
`define CFG_READOUT_N_BIT   6
`define CFG_RESET_PIN_BIT   5
`define CFG_PUT_DIS_BIT     4
`define CFG_WATCHDOG_BIT    3
`define CFGW_UNIMPL_MASK    14'h0287
`define CFGW_ERASED         14'h3FFF
// Program space
`define ID_BASE             14'h2000
`define ID_LAST             14'h2003
`define PROT_NONE           2'b11
`define PROT_400            2'b10
`define PROT_800            2'b01
`define BOUND_400           14'h0400
`define BOUND_800           14'h0800
// Control and status bits
`define CTRL_WREN_BIT       0
`define ST_SELF_BLK_BIT     0
`define ST_EXT_REF_BIT      1
`define ST_LOADED_BIT       2
`endif

/* shared/cfg_prot_pkg.sv */
`include "cfg_prot_params.svh"
package cfg_prot_pkg;
   typedef logic [`WORD_W-1:0] word_t;

   typedef struct packed {
      logic  req;
      logic  we;
      word_t addr;
      word_t wdata;
   } ext_req_s;

   typedef struct packed {
      logic  ack;
      logic  refused;
      word_t rdata;
      logic  mem_we;
      word_t mem_addr;
      word_t mem_wdata;
   } ext_rsp_s;

   typedef struct packed {
      logic  req;
      word_t addr;
      word_t data;
   } self_req_s;

   typedef struct packed {
      logic  strobe;
      logic  blocked;
      word_t addr;
      word_t data;
   } self_rsp_s;

   typedef struct packed {
      logic  req;
      word_t addr;
   } cpu_req_s;

   typedef struct packed {
      logic  valid;
      word_t rdata;
   } cpu_rsp_s;

   typedef struct packed {
      logic       valid;
      logic       debug_mode_en;
      logic [1:0] self_write_protect_range;
      logic       brownout_reset_enable;
      logic       code_protect_active;
      logic       reset_pin_external;
      logic       reset_pin_pullup_en;
      logic       powerup_timer_en;
      logic       watchdog_enable;
   } cfg_decode_s;

   typedef struct packed {
      logic             loaded;
      word_t            cfg;
      logic             wr_en;
      logic             self_blk_flag;
      logic             ext_ref_flag;
      logic [3:0][`WORD_W-1:0] id;
      logic [31:0]      prdata;
      logic             pslverr;
      ext_rsp_s         ext;
      self_rsp_s        self;
      cpu_rsp_s         cpu;
   } state_s;
endpackage

/* core/cfg_write_gate.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cfg_prot_params.svh"
module cfg_write_gate
#(
   parameter int AW = 12
)
(
   input  wire logic [1:0]         i_range,
   input  wire logic [`WORD_W-1:0] i_addr,
   output logic                    o_allow
);
   logic in_mem;

   if (AW < 12 || AW > 13)
   begin : g_bad_aw
      $error("cfg_write_gate: AW must be 12 or 13");
   end

   assign in_mem = ((i_addr >> AW) == '0);

   // Protected block starts at zero and grows as the range code falls
   always_comb
   begin
      case (i_range)
         `PROT_NONE: o_allow = in_mem;
         `PROT_400:  o_allow = in_mem && (i_addr >= `BOUND_400);
         `PROT_800:  o_allow = in_mem && (i_addr >= `BOUND_800);
         default:    o_allow = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* tb/ext_programmer.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_programmer
   import cfg_prot_pkg::*;
(
   input  wire logic     i_core_clk,
   input  wire ext_rsp_s i_rsp,
   output ext_req_s      o_req,
   output word_t         o_mem_rdata
);
   initial o_req = '0;
   // Flash contents behind the programmer
   function automatic word_t flash(input word_t a);
      return a ^ 14'h2A5A;
   endfunction
   // Data only while a request stands, inverted otherwise
   assign o_mem_rdata = o_req.req ? flash(o_req.addr) : ~flash(o_req.addr);
   // One request per call, only in program/verify mode unless a test says otherwise
   task automatic xfer(input logic we, input word_t a, input word_t d, output ext_rsp_s r);
      @(posedge i_core_clk);
      o_req <= '{1'b1, we, a, d};
      @(posedge i_core_clk);
      o_req <= '{1'b0, 1'b0, ~a, ~d};
      #1 r = i_rsp;
   endtask
endmodule
`default_nettype wire

/* tb/config_word_protection_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module config_word_protection_tb import cfg_prot_pkg::*;;
   typedef struct packed {
      word_t nv;
      word_t addr;
      logic  blk;
   } row_s;
   // Words keep debug select high
   row_s rows [7] = '{'{14'h3FFF, 14'h0000, 1'b0}, '{14'h3BFF, 14'h03FF, 1'b1},
                      '{14'h3BFF, 14'h0400, 1'b0}, '{14'h37FF, 14'h07FF, 1'b1},
                      '{14'h37FF, 14'h0800, 1'b0}, '{14'h33FF, 14'h0FFF, 1'b1},
                      '{14'h37BF, 14'h0800, 1'b0}};
   logic        i_core_clk;
   logic        i_rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   word_t       nv;
   cfg_decode_s cfg;
   self_req_s   sw_q;
   self_rsp_s   sw_r;
   word_t       cpu_md;
   cpu_req_s    cpu_q;
   cpu_rsp_s    cpu_r;
   logic        pv;
   ext_req_s    ext_q;
   word_t       ext_md;
   ext_rsp_s    ext_r;
   int          errors;
   int          checked;
   logic [31:0] rd;
   logic        er;
   self_rsp_s   sr;
   cpu_rsp_s    cr;
   ext_rsp_s    xr;

   config_word_protection dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_nv_config_word(nv),
      .o_cfg(cfg), .i_self(sw_q), .o_self(sw_r), .i_cpu_mem_rdata(cpu_md), .i_cpu(cpu_q),
      .o_cpu(cpu_r), .i_pv_mode(pv), .i_ext(ext_q), .i_ext_mem_rdata(ext_md), .o_ext(ext_r));
   ext_programmer prog (.i_core_clk(i_core_clk), .i_rsp(ext_r), .o_req(ext_q),
      .o_mem_rdata(ext_md));

   initial
   begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end

   task automatic stop_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic we, input logic [15:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= we;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      @(posedge i_core_clk);
      while (pready !== 1'b1)
         @(posedge i_core_clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rst(input word_t w);
      i_rst_b <= 1'b0;
      nv      <= w;
      repeat (6) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_core_clk);
   endtask

   task automatic sw(input word_t a);
      @(posedge i_core_clk);
      sw_q <= '{1'b1, a, ~a};
      @(posedge i_core_clk);
      sw_q.req <= 1'b0;
      #1 sr = sw_r;
   endtask

   task automatic cpu(input word_t a, input word_t d);
      @(posedge i_core_clk);
      cpu_q  <= '{1'b1, a};
      cpu_md <= d;
      @(posedge i_core_clk);
      cpu_q.req <= 1'b0;
      cpu_md    <= ~d;
      #1 cr = cpu_r;
   endtask

   initial
   begin
      #400000;
      errors++;
      stop_test();
   end

   initial
   begin
      errors  = 0;
      checked = 0;
      i_rst_b = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
      nv      = 14'h0800;
      sw_q    = '0;
      cpu_q   = '0;
      cpu_md  = '0;
      pv      = 1'b1;
      foreach (rows[i])
      begin
         rst(rows[i].nv);
         apb(1'b1, 16'h0000, 32'h1);
         apb(1'b0, 16'h801C, 32'h0);
         chk(rd, {18'h0, rows[i].nv | 14'h0287});
         chk(cfg.self_write_protect_range, rows[i].nv[11:10]);
         sw(rows[i].addr);
         chk(sr.blocked, rows[i].blk);
         chk(sr.strobe, !rows[i].blk);
         chk({sr.addr, sr.data}, {rows[i].addr, ~rows[i].addr});
      end
      apb(1'b1, 16'h0000, 32'h0);
      sw(14'h0800);
      chk(sr.blocked, 1'b1);
      apb(1'b0, 16'h0004, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, 16'h0004, 32'h1);
      apb(1'b0, 16'h0004, 32'h0);
      chk(rd[0], 1'b0);
      $display("test self_write_rows done");
      i_rst_b <= 1'b0;
      nv      <= 14'h0800;
      repeat (3) @(posedge i_core_clk);
      #1 chk(cfg, 10'b0_0_11_1_0_1_1_0_1);
      repeat (3) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      chk(cfg, 10'b1_1_10_0_1_0_0_1_0);
      apb(1'b0, 16'h0000, 32'h0);
      chk(rd, 32'h0);
      rst(14'h2578);
      chk(cfg, 10'b1_0_01_1_0_1_1_0_1);
      $display("test decode done");
      rst(14'h3FFF);
      prog.xfer(1'b0, 14'h0123, 14'h0000, xr);
      chk(xr.ack, 1'b1);
      chk(xr.rdata, prog.flash(14'h0123));
      prog.xfer(1'b1, 14'h0050, 14'h1234, xr);
      chk({xr.mem_we, xr.mem_addr, xr.mem_wdata}, {1'b1, 14'h0050, 14'h1234});
      prog.xfer(1'b1, 14'h2001, 14'h0055, xr);
      chk({xr.mem_we, xr.refused, xr.mem_addr}, {2'b00, 14'h2001});
      prog.xfer(1'b0, 14'h2001, 14'h0000, xr);
      chk({xr.refused, xr.rdata}, {1'b0, 14'h0055});
      prog.xfer(1'b0, 14'h2007, 14'h0000, xr);
      chk({xr.refused, xr.rdata}, {1'b0, 14'h3FFF});
      prog.xfer(1'b1, 14'h2007, 14'h1234, xr);
      chk({xr.mem_we, xr.mem_addr, xr.mem_wdata}, {1'b1, 14'h2007, 14'h1234});
      chk(cfg.self_write_protect_range, 2'b11);
      prog.xfer(1'b0, 14'h1500, 14'h0000, xr);
      chk({xr.refused, xr.rdata}, {1'b1, 14'h0000});
      pv <= 1'b0;
      prog.xfer(1'b0, 14'h2002, 14'h0000, xr);
      chk(xr.refused, 1'b1);
      cpu(14'h2001, 14'h1555);
      chk(cr.rdata, 14'h0000);
      $display("test ext_open done");
      rst(14'h3FBF);
      pv <= 1'b1;
      prog.xfer(1'b0, 14'h0123, 14'h0000, xr);
      chk({xr.refused, xr.rdata}, 15'h0000);
      prog.xfer(1'b1, 14'h0050, 14'h1234, xr);
      chk({xr.refused, xr.mem_we}, 2'b10);
      prog.xfer(1'b0, 14'h0FFF, 14'h0000, xr);
      chk(xr.rdata, 14'h0000);
      cpu(14'h0123, 14'h1ABC);
      chk({cr.valid, cr.rdata}, {1'b1, 14'h1ABC});
      apb(1'b0, 16'h0004, 32'h0);
      chk(rd[2:1], 2'b11);
      apb(1'b1, 16'h801C, 32'h0);
      apb(1'b0, 16'h801C, 32'h0);
      chk(rd, 32'h3FBF);
      chk(cfg.code_protect_active, 1'b1);
      apb(1'b0, 16'h0100, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test ext_protect done");
      stop_test();
   end
endmodule
`default_nettype wire
